// File: hdl/dif_decoder.sv
// Purpose: decode digital and analogue control inputs of a drive
// Assumes: field pins are asynchronous; analogue codes come from this clock
// Notes:   references are in units of 0.1 % of full scale
`timescale 1ns/100ps
module dif_decoder
  import dif_pkg::*;
#(
  parameter int PULSE_MIN = PULSE_MIN_CYCLES,
  parameter int TICK_LEN  = TICK_CYCLES
) (
  input  wire logic                       clock,
  input  wire logic                       reset,
  input  wire logic                       speedUpPin,
  input  wire logic                       speedDownPin,
  input  wire logic                       catchUpPin,
  input  wire logic                       slowDownPin,
  input  wire logic                       rampSelPin,
  input  wire logic                       presetLsbPin,
  input  wire logic                       presetMsbPin,
  input  wire logic                       presetOnPin,
  input  wire logic                       accurate_halt_n,
  input  wire logic                       setupLsbPin,
  input  wire logic                       setupMsbPin,
  input  wire logic                       resetStartPin,
  input  wire logic                       trackAPin,
  input  wire logic                       trackBPin,
  input  wire logic                       freezeRef,
  input  wire logic                       freezeOut,
  input  wire logic                       motorRunning,
  input  wire logic                       multiSetup,
  input  wire logic [1:0]                 refFunction,
  input  wire logic [15:0]                remoteRef,
  input  wire logic [15:0]                adjustPercent,
  input  wire logic                       presetWrite,
  input  wire logic [1:0]                 presetWriteIdx,
  input  wire logic [15:0]                presetWriteData,
  input  wire logic                       frozenRestore,
  input  wire logic [15:0]                frozenRestoreValue,
  input  wire dif_pkg::dif_pulse_cfg_type pulseCfg,
  input  wire logic [15:0]                pulseFreq,
  input  wire dif_pkg::dif_ain_cfg_type   voltCfg,
  input  wire dif_pkg::dif_ain_cfg_type   currCfg,
  input  wire logic [7:0]                 voltLevel,
  input  wire logic [7:0]                 currLevel,
  input  wire logic [6:0]                 timeoutSec,
  input  wire dif_pkg::dif_timeout_type   timeoutAction,
  output logic [15:0]                     refOut,
  output logic [15:0]                     frozenRef,
  output logic [15:0]                     feedbackOut,
  output logic [15:0]                     wobbleOut,
  output logic                            ramp2Sel,
  output logic [1:0]                      setupSel,
  output logic                            haltReq,
  output logic                            alarmClear,
  output logic                            startReq,
  output logic signed [15:0]              encoderPos,
  output dif_pkg::dif_timeout_type        timeoutFire,
  output logic                            timeoutOverridesBus
);
  import dif_pkg::*;

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function automatic logic [15:0] scaleLin(input logic [15:0] x, input logic [15:0] lo, input logic [15:0] hi);
    logic [31:0] num;
    num = 32'h0;
    if (hi <= lo || x <= lo) begin
      scaleLin = 16'h0;
    end else if (x >= hi) begin
      scaleLin = FULL_SCALE;
    end else begin
      num = 32'(x - lo) * 32'(FULL_SCALE);
      scaleLin = 16'(num / 32'(hi - lo));
    end
  endfunction : scaleLin

  function automatic logic [15:0] satAdd(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    satAdd = s[16] ? 16'hffff : s[15:0];
  endfunction : satAdd

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  localparam int NPIN = 14;
  logic [NPIN-1:0] pinRaw, syncA_q, syncB_q;
  assign pinRaw = {speedUpPin, speedDownPin, catchUpPin, slowDownPin, rampSelPin, presetLsbPin,
                   presetMsbPin, presetOnPin, accurate_halt_n, setupLsbPin, setupMsbPin,
                   resetStartPin, trackAPin, trackBPin};
  always_ff @(posedge clock) begin
    if (reset) begin
      syncA_q <= 14'h0020;  // halt line idles high
      syncB_q <= 14'h0020;  // halt line idles high
    end else begin
      syncA_q <= pinRaw;
      syncB_q <= syncA_q;
    end
  end
  logic upS, downS, catchS, slowS, rampS, pLsbS, pMsbS, pOnS, haltNS, sLsbS, sMsbS, rstStS, trkA, trkB;
  assign {upS, downS, catchS, slowS, rampS, pLsbS, pMsbS, pOnS, haltNS, sLsbS, sMsbS, rstStS, trkA, trkB} = syncB_q;

  // ----------------------------------------
  // speed pulse qualifier
  // ----------------------------------------
  logic [1:0]  lineState;
  logic        pulseActive;
  logic        highOk_q, lowOk_q, inHigh_q;
  logic [31:0] phaseCnt_q;
  logic [1:0]  heldDir_q;
  logic        stepUp, stepDown;
  assign lineState   = {downS, upS};
  assign pulseActive = lineState != 2'b00;
  always_ff @(posedge clock) begin
    if (reset) begin
      phaseCnt_q <= '0;
      inHigh_q   <= 1'b0;
      highOk_q   <= 1'b0;
      lowOk_q    <= 1'b0;
      heldDir_q  <= 2'b00;
    end else if (pulseActive != inHigh_q) begin
      inHigh_q   <= pulseActive;
      phaseCnt_q <= '0;
      if (!pulseActive) begin
        highOk_q <= 1'b0;
      end
      if (pulseActive) begin
        heldDir_q <= lineState;
        if (phaseCnt_q < 32'(PULSE_MIN)) begin
          lowOk_q <= 1'b0;
        end
      end
    end else begin
      if (phaseCnt_q < 32'(PULSE_MIN)) begin
        phaseCnt_q <= phaseCnt_q + 32'h1;
      end else if (!inHigh_q) begin
        lowOk_q <= 1'b1;
      end else begin
        highOk_q <= 1'b1;
      end
    end
  end
  // step is issued on the falling edge of a fully qualified pulse
  logic validPulse;
  assign validPulse = inHigh_q && !pulseActive && highOk_q && lowOk_q && (freezeRef || freezeOut);
  assign stepUp     = validPulse && heldDir_q == 2'b01;
  assign stepDown   = validPulse && heldDir_q[1];

  // ----------------------------------------
  // frozen reference
  // ----------------------------------------
  logic [15:0] frozen_q;
  always_ff @(posedge clock) begin
    if (reset) begin
      frozen_q <= '0;
    end else if (frozenRestore) begin
      frozen_q <= frozenRestoreValue;
    end else if (stepUp) begin
      frozen_q <= satAdd(frozen_q, STEP_SIZE);
    end else if (stepDown) begin
      frozen_q <= (frozen_q > STEP_SIZE) ? frozen_q - STEP_SIZE : 16'h0;
    end
  end

  // ----------------------------------------
  // preset store and selection
  // ----------------------------------------
  logic [15:0] presetVal;
  dif_preset_mem #(.WIDTH(16)) presets (
    .clock     (clock),
    .writeEn   (presetWrite),
    .writeIdx  (presetWriteIdx),
    .writeData (presetWriteData),
    .readIdx   ({pMsbS, pLsbS}),
    .readData  (presetVal)
  );

  // ----------------------------------------
  // quadrature and pulse counting
  // ----------------------------------------
  logic [1:0]  quadPrev_q;
  logic        aPrev_q;
  logic [15:0] count_q;
  logic        countHalt_q;
  logic        quadMove, quadFwd, countEdge;
  assign quadMove  = {trkA, trkB} != quadPrev_q;
  assign quadFwd   = (trkA ^ quadPrev_q[0]);
  assign countEdge = (pulseCfg.mode == PM_ENCODER) ? quadMove : (trkA && !aPrev_q);
  always_ff @(posedge clock) begin
    if (reset) begin
      quadPrev_q  <= 2'b00;
      aPrev_q     <= 1'b0;
      encoderPos  <= '0;
      count_q     <= '0;
      countHalt_q <= 1'b0;
    end else begin
      quadPrev_q <= {trkA, trkB};
      aPrev_q    <= trkA;
      if (pulseCfg.mode == PM_ENCODER && quadMove) begin
        encoderPos <= quadFwd ? encoderPos + 16'sh1 : encoderPos - 16'sh1;
      end
      if (pulseCfg.role != PU_COUNT || pulseCfg.mode == PM_OFF || rstStS) begin
        count_q     <= '0;
        countHalt_q <= 1'b0;
      end else if (count_q >= pulseCfg.countLimit) begin
        countHalt_q <= 1'b1;
      end else if (countEdge) begin
        count_q <= count_q + 16'h1;
      end
    end
  end

  // ----------------------------------------
  // analogue inputs
  // ----------------------------------------
  logic [15:0] voltScaled, currScaled, pulseScaled;
  assign voltScaled  = scaleLin({8'h0, voltLevel}, {8'h0, voltCfg.lo}, {8'h0, voltCfg.hi});
  assign currScaled  = scaleLin({8'h0, currLevel}, {8'h0, currCfg.lo}, {8'h0, currCfg.hi});
  assign pulseScaled = scaleLin(pulseFreq, 16'h0, pulseCfg.maxFreq);

  // ----------------------------------------
  // reference, feedback and wobble
  // ----------------------------------------
  logic [15:0] baseRef, sumRef, adjRef, fbNext, wobNext, adjAmt;
  logic [31:0] adjProd;
  always_comb begin
    baseRef = (refFunction == REFFN_EXT_PRESET && pOnS) ? presetVal : remoteRef;
    if (freezeRef) begin
      baseRef = frozen_q;
    end
    sumRef = baseRef;
    if (voltCfg.func == AIN_REF) begin
      sumRef = satAdd(sumRef, voltScaled);
    end
    if (currCfg.func == AIN_REF) begin
      sumRef = satAdd(sumRef, currScaled);
    end
    if (pulseCfg.mode != PM_OFF && pulseCfg.role == PU_REF) begin
      sumRef = satAdd(sumRef, pulseScaled);
    end
    adjProd = 32'(sumRef) * 32'(adjustPercent);
    adjAmt  = 16'(adjProd / 32'(FULL_SCALE));
    if (slowS) begin
      adjRef = (sumRef > adjAmt) ? sumRef - adjAmt : 16'h0;
    end else if (catchS) begin
      adjRef = satAdd(sumRef, adjAmt);
    end else begin
      adjRef = sumRef;
    end
    fbNext = 16'h0;
    if (voltCfg.func == AIN_FEEDBACK) begin
      fbNext = voltScaled;
    end else if (currCfg.func == AIN_FEEDBACK) begin
      fbNext = currScaled;
    end else if (pulseCfg.mode != PM_OFF && pulseCfg.role == PU_FEEDBACK) begin
      fbNext = pulseScaled;
    end
    wobNext = 16'h0;
    if (voltCfg.func == AIN_WOBBLE) begin
      wobNext = voltScaled;
    end else if (currCfg.func == AIN_WOBBLE) begin
      wobNext = currScaled;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      refOut      <= '0;
      frozenRef   <= '0;
      feedbackOut <= '0;
      wobbleOut   <= '0;
    end else begin
      refOut      <= adjRef;
      frozenRef   <= frozen_q;
      feedbackOut <= fbNext;
      wobbleOut   <= wobNext;
    end
  end

  // ----------------------------------------
  // ramp, setup, halt and start
  // ----------------------------------------
  logic rstStPrev_q;
  always_ff @(posedge clock) begin
    if (reset) begin
      ramp2Sel    <= 1'b0;
      setupSel    <= 2'b00;
      haltReq     <= 1'b0;
      alarmClear  <= 1'b0;
      startReq    <= 1'b0;
      rstStPrev_q <= 1'b0;
    end else begin
      ramp2Sel    <= rampS || ((freezeRef || freezeOut) && motorRunning && pulseActive);
      if (multiSetup) begin
        setupSel <= {sMsbS, sLsbS};
      end
      haltReq     <= !haltNS || countHalt_q;
      rstStPrev_q <= rstStS;
      alarmClear  <= rstStS && !rstStPrev_q;
      startReq    <= rstStS && rstStPrev_q;
    end
  end

  // ----------------------------------------
  // signal-loss supervision
  // ----------------------------------------
  logic        voltWatch, currWatch, lowSignal;
  logic [31:0] tickCnt_q;
  logic [10:0] lowTicks_q;
  logic [10:0] limitTicks;
  logic [6:0]  toSec;
  assign voltWatch = (voltCfg.func == AIN_REF || voltCfg.func == AIN_FEEDBACK) && voltCfg.lo > VOLT_SUP_MIN;
  assign currWatch = (currCfg.func == AIN_REF || currCfg.func == AIN_FEEDBACK) && currCfg.lo > CURR_SUP_MIN;
  assign lowSignal = (voltWatch && {voltLevel, 1'b0} < {1'b0, voltCfg.lo})
                  || (currWatch && {currLevel, 1'b0} < {1'b0, currCfg.lo});
  assign toSec      = (timeoutSec < 7'(TIMEOUT_MIN_S)) ? 7'(TIMEOUT_MIN_S)
                    : (timeoutSec > 7'(TIMEOUT_MAX_S)) ? 7'(TIMEOUT_MAX_S) : timeoutSec;
  assign limitTicks = 11'(toSec * TICKS_PER_S);
  always_ff @(posedge clock) begin
    if (reset) begin
      tickCnt_q           <= '0;
      lowTicks_q          <= '0;
      timeoutFire         <= TO_NONE;
      timeoutOverridesBus <= 1'b0;
    end else begin
      if (!lowSignal) begin
        tickCnt_q   <= '0;
        lowTicks_q  <= '0;
        timeoutFire <= TO_NONE;
      end else if (lowTicks_q > limitTicks) begin
        timeoutFire <= (timeoutAction > TO_TRIP) ? TO_NONE : timeoutAction;
      end else if (tickCnt_q >= 32'(TICK_LEN - 1)) begin
        tickCnt_q  <= '0;
        lowTicks_q <= lowTicks_q + 11'h1;
      end else begin
        tickCnt_q <= tickCnt_q + 32'h1;
      end
      timeoutOverridesBus <= lowSignal && lowTicks_q > limitTicks && timeoutAction != TO_NONE;
    end
  end
endmodule : dif_decoder

// File: hdl/dif_preset_mem.sv
// Purpose: four-word preset reference store, registered read
// Assumes: single write port, single read port
// Notes:   read data one cycle after the index
`timescale 1ns/100ps
module dif_preset_mem #(
  parameter int WIDTH = 16
) (
  input  wire logic             clock,
  input  wire logic             writeEn,
  input  wire logic [1:0]       writeIdx,
  input  wire logic [WIDTH-1:0] writeData,
  input  wire logic [1:0]       readIdx,
  output logic      [WIDTH-1:0] readData
);
  logic [WIDTH-1:0] store [4];
  always_ff @(posedge clock) begin
    if (writeEn) begin
      store[writeIdx] <= writeData;
    end
    readData <= store[readIdx];
  end
endmodule : dif_preset_mem

// File: pkg/dif_pkg.sv
// Purpose: shared constants and types for the drive input function decoder
// Assumes: 25 MHz control clock; analogue values arrive as digitised codes
// Notes:   voltage in units of 0.1 V, current in units of 0.1 mA
package dif_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLOCK_HZ          = 25000000;
  localparam int PULSE_MIN_MS      = 14;
  localparam int PULSE_MIN_CYCLES  = (CLOCK_HZ / 1000) * PULSE_MIN_MS;
  localparam int TIMEOUT_DEF_S     = 10;
  localparam int TIMEOUT_MIN_S     = 1;
  localparam int TIMEOUT_MAX_S     = 99;
  localparam int TICK_MS           = 100;
  localparam int TICK_CYCLES       = (CLOCK_HZ / 1000) * TICK_MS;
  localparam int TICKS_PER_S       = 1000 / TICK_MS;
  // ----------------------------------------
  // scaling (0.1 V / 0.1 mA units)
  // ----------------------------------------
  localparam logic [7:0] VOLT_MIN_DEF  = 8'h00;
  localparam logic [7:0] VOLT_MAX_DEF  = 8'h64;
  localparam logic [7:0] VOLT_SUP_MIN  = 8'h0a;
  localparam logic [7:0] CURR_MIN_DEF  = 8'h28;
  localparam logic [7:0] CURR_MAX_DEF  = 8'hc8;
  localparam logic [7:0] CURR_SUP_MIN  = 8'h14;
  localparam logic [15:0] FULL_SCALE   = 16'h03e8;
  localparam logic [15:0] STEP_SIZE    = 16'h0001;
  // ----------------------------------------
  // function codes
  // ----------------------------------------
  localparam logic [3:0] AIN_NONE      = 4'h0;
  localparam logic [3:0] AIN_REF       = 4'h1;
  localparam logic [3:0] AIN_FEEDBACK  = 4'h2;
  localparam logic [3:0] AIN_WOBBLE    = 4'ha;
  localparam logic [3:0] CURR_FUNC_DEF = AIN_FEEDBACK;
  localparam logic [1:0] REFFN_EXT_PRESET = 2'h2;
  typedef enum logic [2:0] {
    TO_NONE   = 3'h0,
    TO_FREEZE = 3'h1,
    TO_STOP   = 3'h2,
    TO_JOG    = 3'h3,
    TO_MAX    = 3'h4,
    TO_TRIP   = 3'h5
  } dif_timeout_type;
  typedef enum logic [2:0] {
    PM_OFF      = 3'h0,
    PM_PULSE    = 3'h1,
    PM_ENCODER  = 3'h2
  } dif_pulse_mode_type;
  typedef enum logic [2:0] {
    PU_REF      = 3'h0,
    PU_FEEDBACK = 3'h1,
    PU_COUNT    = 3'h2
  } dif_pulse_use_type;
  typedef struct packed {
    logic [3:0] func;
    logic [7:0] lo;
    logic [7:0] hi;
  } dif_ain_cfg_type;
  typedef struct packed {
    logic [15:0] maxFreq;
    logic [15:0] countLimit;
    dif_pulse_mode_type mode;
    dif_pulse_use_type  role;
  } dif_pulse_cfg_type;
endpackage : dif_pkg

// File: verification/dif_decoder_monitor.sv
// Purpose: port-level assertions for the input function decoder
// Assumes: single clock, synchronous active-high reset
// Notes:   bound to every dif_decoder instance
`timescale 1ns/100ps
module dif_decoder_checker
  import dif_pkg::*;
(
  input wire logic                     clock,
  input wire logic                     reset,
  input wire logic                     rampSelPin,
  input wire logic                     accurate_halt_n,
  input wire logic                     resetStartPin,
  input wire logic                     multiSetup,
  input wire logic                     freezeRef,
  input wire logic                     freezeOut,
  input wire logic                     frozenRestore,
  input wire dif_pkg::dif_timeout_type timeoutAction,
  input wire logic                     ramp2Sel,
  input wire logic [1:0]               setupSel,
  input wire logic                     haltReq,
  input wire logic                     alarmClear,
  input wire logic                     startReq,
  input wire logic [15:0]              frozenRef,
  input wire dif_pkg::dif_timeout_type timeoutFire,
  input wire logic                     timeoutOverridesBus
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  chk_ramp_follow: assert property (rampSelPin [*5] |-> ramp2Sel)
    else $error("ramp select not followed");
  chk_halt_follow: assert property (!accurate_halt_n [*5] |-> haltReq)
    else $error("halt input not followed");
  chk_setup_hold: assert property (!multiSetup && !$past(multiSetup) |-> $stable(setupSel))
    else $error("setup moved without multisetup");
  chk_clear_pulse: assert property (alarmClear |=> !alarmClear)
    else $error("alarm clear longer than one cycle");
  chk_start_cause: assert property (startReq |-> $past(resetStartPin, 3))
    else $error("start without reset-and-start input");
  chk_fire_action: assert property (timeoutFire != TO_NONE && $stable(timeoutAction)
    |-> timeoutFire == timeoutAction)
    else $error("timeout action code wrong");
  chk_bus_override: assert property (timeoutFire != TO_NONE |-> timeoutOverridesBus)
    else $error("timeout does not override bus");
  chk_step_size: assert property (frozenRef != $past(frozenRef) && !$past(frozenRestore)
    && !$past(frozenRestore, 2) |-> (frozenRef - $past(frozenRef)) == 16'h0001
    || ($past(frozenRef) - frozenRef) == 16'h0001)
    else $error("frozen step not one unit");
  chk_step_frozen: assert property (frozenRef != $past(frozenRef) && !$past(frozenRestore)
    && !$past(frozenRestore, 2) |-> $past(freezeRef) || $past(freezeOut)
    || $past(freezeRef, 2) || $past(freezeOut, 2))
    else $error("frozen value moved outside freeze mode");
endmodule : dif_decoder_checker

bind dif_decoder dif_decoder_checker chk (.clock(clock), .reset(reset), .rampSelPin(rampSelPin),
  .accurate_halt_n(accurate_halt_n), .resetStartPin(resetStartPin), .multiSetup(multiSetup),
  .freezeRef(freezeRef), .freezeOut(freezeOut), .frozenRestore(frozenRestore),
  .timeoutAction(timeoutAction), .ramp2Sel(ramp2Sel), .setupSel(setupSel), .haltReq(haltReq),
  .alarmClear(alarmClear), .startReq(startReq), .frozenRef(frozenRef), .timeoutFire(timeoutFire),
  .timeoutOverridesBus(timeoutOverridesBus));

// File: verification/dif_field_model.sv
// Purpose: field-side source of speed pulses and encoder tracks
// Assumes: levels change 1 ns after the rising clock edge
// Notes:   gaps of 25 cycles keep the shortened pulse minimum
`timescale 1ns/100ps
module dif_field_model (
  input  wire logic clock,
  output logic      speedUpPin,
  output logic      speedDownPin,
  output logic      trackAPin,
  output logic      trackBPin
);
  initial begin
    {speedUpPin, speedDownPin, trackAPin, trackBPin} = 4'h0;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc
  // low gap before and after each high phase
  task automatic speed_pulse(input logic up, input logic dn, input int hiCy);
    cyc(25);
    {speedUpPin, speedDownPin} = {up, dn};
    cyc(hiCy);
    {speedUpPin, speedDownPin} = 2'h0;
    cyc(25);
  endtask : speed_pulse
  // track A on first input, leading B when forward
  task automatic quad(input logic fwd, input int n);
    repeat (n) begin
      if ((trackAPin == trackBPin) == fwd) trackAPin = !trackAPin;
      else trackBPin = !trackBPin;
      cyc(4);
    end
  endtask : quad
  task automatic a_pulses(input int n);
    repeat (n) begin
      trackAPin = 1'b1;
      cyc(4);
      trackAPin = 1'b0;
      cyc(4);
    end
  endtask : a_pulses
endmodule : dif_field_model

// File: verification/tb.sv
// Purpose: self-checking bench for the input function decoder
// Assumes: shortened pulse minimum 20 and tick 10 cycles
// Notes:   inputs change 1 ns after the rising edge
`timescale 1ns/100ps
module tb;
  import dif_pkg::*;
  logic clock, reset, catchUpPin, slowDownPin, rampSelPin, presetLsbPin, presetMsbPin, presetOnPin;
  logic accurate_halt_n, setupLsbPin, setupMsbPin, resetStartPin, freezeRef, freezeOut, motorRunning;
  logic multiSetup, presetWrite, frozenRestore, speedUpPin, speedDownPin, trackAPin, trackBPin;
  logic [1:0] refFunction, presetWriteIdx, setupSel;
  logic [15:0] remoteRef, adjustPercent, presetWriteData, frozenRestoreValue, pulseFreq;
  logic [15:0] refOut, frozenRef, feedbackOut, wobbleOut;
  logic [7:0] voltLevel, currLevel;
  logic [6:0] timeoutSec;
  logic ramp2Sel, haltReq, alarmClear, startReq, timeoutOverridesBus;
  logic signed [15:0] encoderPos;
  dif_pulse_cfg_type pulseCfg;
  dif_ain_cfg_type voltCfg, currCfg;
  dif_timeout_type timeoutAction, timeoutFire;
  int badCount, checkCount, n;
  logic [15:0] adj[4] = '{16'h01f4, 16'h0226, 16'h01c2, 16'h01c2};
  dif_decoder #(.PULSE_MIN(20), .TICK_LEN(10)) dut (.clock, .reset, .speedUpPin, .speedDownPin,
    .catchUpPin, .slowDownPin, .rampSelPin, .presetLsbPin, .presetMsbPin, .presetOnPin, .accurate_halt_n,
    .setupLsbPin, .setupMsbPin, .resetStartPin, .trackAPin, .trackBPin, .freezeRef, .freezeOut,
    .motorRunning, .multiSetup, .refFunction, .remoteRef, .adjustPercent, .presetWrite, .presetWriteIdx,
    .presetWriteData, .frozenRestore, .frozenRestoreValue, .pulseCfg, .pulseFreq, .voltCfg, .currCfg,
    .voltLevel, .currLevel, .timeoutSec, .timeoutAction, .refOut, .frozenRef, .feedbackOut, .wobbleOut,
    .ramp2Sel, .setupSel, .haltReq, .alarmClear, .startReq, .encoderPos, .timeoutFire, .timeoutOverridesBus);
  dif_field_model fld (.clock, .speedUpPin, .speedDownPin, .trackAPin, .trackBPin);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #20 clock = !clock;
  end
  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask : cyc
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checkCount++;
    if (got !== exp) begin
      badCount++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", checkCount, badCount);
    if (badCount == 0 && checkCount > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : giveVerdict
  initial begin
    repeat (20000) @(posedge clock);
    badCount++;
    giveVerdict();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    {reset, accurate_halt_n} = 2'h3;
    {catchUpPin, slowDownPin, rampSelPin, presetLsbPin, presetMsbPin, presetOnPin} = 6'h00;
    {setupLsbPin, setupMsbPin, resetStartPin, freezeRef, freezeOut, motorRunning} = 6'h00;
    {multiSetup, presetWrite, frozenRestore, refFunction, presetWriteIdx} = 7'h00;
    {remoteRef, adjustPercent, presetWriteData, frozenRestoreValue, pulseFreq} = 80'h0;
    {voltLevel, currLevel, timeoutSec} = {16'h0, 7'h01};
    pulseCfg = '{16'h03e8, 16'h0003, PM_ENCODER, PU_REF};
    voltCfg = '{AIN_NONE, VOLT_MIN_DEF, VOLT_MAX_DEF};
    currCfg = '{CURR_FUNC_DEF, CURR_MIN_DEF, CURR_MAX_DEF};
    timeoutAction = TO_NONE;
    cyc(6);
    reset = 1'b0;
    cyc(3);
    fld.quad(1'b1, 4);
    chk("encoderPos", 16'h0004, encoderPos);
    fld.quad(1'b0, 8);
    chk("encoderPos", 16'hfffc, encoderPos);
    $display("test encoder done");
    rampSelPin = 1'b1;
    cyc(5);
    chk("ramp2Sel", 16'h0001, 16'(ramp2Sel));
    {rampSelPin, setupMsbPin, setupLsbPin} = 3'h3;
    cyc(5);
    chk("ramp2Sel", 16'h0000, 16'(ramp2Sel));
    chk("setupSel", 16'h0000, 16'(setupSel));
    multiSetup = 1'b1;
    cyc(5);
    chk("setupSel", 16'h0003, 16'(setupSel));
    $display("test select done");
    for (int i = 0; i < 4; i++) begin
      {presetWrite, presetWriteIdx, presetWriteData} = {1'b1, 2'(i), 16'h0064 * 16'(i + 1)};
      cyc(1);
    end
    {presetWrite, refFunction, presetOnPin, remoteRef} = {1'b0, REFFN_EXT_PRESET, 1'b1, 16'h0384};
    for (int i = 0; i < 4; i++) begin
      {presetMsbPin, presetLsbPin} = 2'(i);
      cyc(6);
      chk("refOut preset", 16'h0064 * 16'(i + 1), refOut);
    end
    {presetOnPin, remoteRef, adjustPercent} = {1'b0, 16'h01f4, 16'h0064};
    cyc(6);
    chk("refOut remote", 16'h01f4, refOut);
    for (int i = 0; i < 4; i++) begin
      {slowDownPin, catchUpPin} = 2'(i);
      cyc(6);
      chk("refOut adjust", adj[i], refOut);
    end
    {slowDownPin, catchUpPin, remoteRef} = {2'h0, 16'h00c8};
    $display("test reference done");
    voltCfg = '{AIN_REF, 8'h00, 8'h64};
    {voltLevel, currLevel} = 16'h3278;
    cyc(6);
    chk("refOut sum", 16'h02bc, refOut);
    chk("feedbackOut", 16'h01f4, feedbackOut);
    currCfg.func = AIN_WOBBLE;
    cyc(3);
    chk("wobbleOut", 16'h01f4, wobbleOut);
    {voltCfg.func, currCfg.func, pulseFreq} = {AIN_NONE, AIN_NONE, 16'h00fa};
    pulseCfg.mode = PM_PULSE;
    cyc(3);
    chk("refOut pulse", 16'h01c2, refOut);
    pulseCfg.role = PU_FEEDBACK;
    cyc(3);
    chk("feedbackOut pulse", 16'h00fa, feedbackOut);
    pulseCfg.role = PU_COUNT;
    cyc(3);
    fld.a_pulses(2);
    chk("haltReq", 16'h0000, 16'(haltReq));
    fld.a_pulses(1);
    chk("haltReq", 16'h0001, 16'(haltReq));
    resetStartPin = 1'b1;
    n = 0;
    repeat (8) begin
      cyc(1);
      if (alarmClear === 1'b1) n++;
    end
    chk("alarmClear", 16'h0001, 16'(n));
    chk("startReq", 16'h0001, 16'(startReq));
    chk("haltReq", 16'h0000, 16'(haltReq));
    {resetStartPin, accurate_halt_n} = 2'h0;
    pulseCfg.mode = PM_OFF;
    cyc(5);
    chk("haltReq", 16'h0001, 16'(haltReq));
    accurate_halt_n = 1'b1;
    $display("test analogue and counting done");
    {freezeRef, frozenRestore, frozenRestoreValue} = {2'h3, 16'h0064};
    cyc(1);
    frozenRestore = 1'b0;
    cyc(4);
    chk("frozenRef", 16'h0064, frozenRef);
    fld.speed_pulse(1'b1, 1'b0, 25);
    chk("frozenRef up", 16'h0065, frozenRef);
    fld.speed_pulse(1'b1, 1'b0, 10);
    chk("frozenRef glitch", 16'h0065, frozenRef);
    fld.speed_pulse(1'b0, 1'b1, 25);
    fld.speed_pulse(1'b1, 1'b1, 25);
    chk("frozenRef down", 16'h0063, frozenRef);
    freezeRef = 1'b0;
    fld.speed_pulse(1'b1, 1'b0, 25);
    chk("frozenRef idle", 16'h0063, frozenRef);
    {freezeOut, motorRunning} = 2'h3;
    fork
      fld.speed_pulse(1'b1, 1'b0, 25);
      begin
        cyc(40);
        chk("ramp2Sel pulse", 16'h0001, 16'(ramp2Sel));
      end
    join
    chk("frozenRef output", 16'h0064, frozenRef);
    $display("test speed pulses done");
    voltCfg = '{AIN_REF, 8'h14, 8'h64};
    for (int a = 0; a < 6; a++) begin
      timeoutAction = dif_timeout_type'(a);
      voltLevel = 8'h05;
      cyc(90);
      chk("timeoutFire early", 16'h0000, 16'(timeoutFire));
      cyc(60);
      chk("timeoutFire", 16'(a), 16'(timeoutFire));
      if (a != 0) chk("timeoutOverridesBus", 16'h0001, 16'(timeoutOverridesBus));
      voltLevel = 8'h32;
      cyc(3);
      chk("timeoutFire cleared", 16'h0000, 16'(timeoutFire));
    end
    {voltCfg.lo, voltLevel} = 16'h0a00;
    cyc(150);
    chk("timeoutFire 1V", 16'h0000, 16'(timeoutFire));
    {voltCfg.func, currCfg, currLevel} = {AIN_NONE, AIN_FEEDBACK, 16'h14c8, 8'h00};
    cyc(150);
    chk("timeoutFire 2mA", 16'h0000, 16'(timeoutFire));
    currCfg.lo = 8'h15;
    cyc(150);
    chk("timeoutFire current", 16'(TO_TRIP), 16'(timeoutFire));
    $display("test timeout done");
    giveVerdict();
  end
endmodule : tb
